// file: pkg/panel_timing_pkg.sv
// Constants shared by the panel switch strobe timing block.
// Assumes a single system clock and register indices that come from the serial access logic.
package panel_timing_pkg;

    // Register indices as seen by the serial configuration logic.
    localparam logic [7:0] RED_START_IDX = 8'h24;
    localparam logic [7:0] RED_END_IDX = 8'h25;
    localparam logic [7:0] GREEN_START_IDX = 8'h26;
    localparam logic [7:0] GREEN_END_IDX = 8'h27;
    localparam logic [7:0] BLUE_START_IDX = 8'h28;
    localparam logic [7:0] BLUE_END_IDX = 8'h29;
    localparam logic [7:0] AUX1_START_TIMING_IDX = 8'h2A;
    localparam logic [7:0] AUX1_END_TIMING_IDX = 8'h2B;
    localparam logic [7:0] AUX2_START_IDX = 8'h2C;
    localparam logic [7:0] AUX2_END_IDX = 8'h2D;
    localparam logic [7:0] AUX3_START_IDX = 8'h2E;
    localparam logic [7:0] AUX3_END_IDX = 8'h2F;
    localparam logic [7:0] AUX_OUTPUT_FUNCTION_IDX = 8'h30;
    localparam logic [7:0] GATE_ENABLE1_START_IDX = 8'h31;
    localparam logic [7:0] GATE_ENABLE1_END_IDX = 8'h32;
    localparam logic [7:0] DUMMY_LINE_SELECT_IDX = 8'h33;

    // Number of start/end timing slots: six strobes in pairs, then the gate enable pair.
    localparam int TIMING_SLOTS = 14;
    localparam logic [3:0] GATE_START_SLOT = 4'hC;
    localparam logic [3:0] GATE_END_SLOT = 4'hD;

    // Width of a timing value and the legal range of programmed counts.
    localparam int TIMING_WIDTH = 6;
    localparam logic [5:0] TIMING_MIN = 6'h01;
    localparam logic [5:0] TIMING_MAX = 6'h3B;

    // Reference clock: a line of 240 pixels splits into 60 quarter periods.
    localparam int LINE_PIXELS = 240;
    localparam int PIXELS_PER_REF = 4;
    localparam int REF_PER_LINE = LINE_PIXELS / PIXELS_PER_REF;

    // Field positions in the auxiliary function register.
    localparam int AUX2_LINE_POS_BIT = 0;
    localparam int AUX2_FRAME_POS_BIT = 1;
    localparam int AUX3_LINE_NEG_BIT = 2;
    localparam int AUX3_FRAME_NEG_BIT = 3;
    localparam int AUX_INVERT_BIT = 7;
    localparam logic [7:0] AUX_FUNCTION_MASK = 8'h8F;

    // Field position of the dummy line select bit.
    localparam int DUMMY_SEL_BIT = 0;

    // Values after reset.
    localparam logic [5:0] TIMING_RESET = 6'h00;
    localparam logic [7:0] AUX_FUNCTION_RESET = 8'h00;
    localparam logic DUMMY_SEL_RESET = 1'b1;

endpackage : panel_timing_pkg

// file: logic/strobe_window.sv
// One strobe window: goes active at the start count and inactive at the end count.
// Assumes the reference count and the window bounds are stable on the block's own clock.
`timescale 1ns/10ps
module strobe_window #(
    parameter int WIDTH = 6
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic line_start_i,
    input wire logic [WIDTH-1:0] ref_count_i,
    input wire logic [WIDTH-1:0] start_i,
    input wire logic [WIDTH-1:0] end_i,
    output logic active_o
);

    // Set on the start count, cleared on the end count; the end count wins if both match.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            active_o <= 1'b0;
        end else if (ce_i) begin
            if (line_start_i) begin
                active_o <= 1'b0;
            end else if (ref_count_i == end_i) begin
                active_o <= 1'b0;
            end else if (ref_count_i == start_i) begin
                active_o <= 1'b1;
            end
        end
    end

endmodule : strobe_window

// file: logic/panel_switch_signal_timing.sv
// Colour switch strobes, auxiliary outputs and first gate output-enable for each line.
// Assumes line, frame, pixel and polarity inputs come from sync logic on sys_clk_i,
// and register writes come from the serial configuration logic on the same clock.
//
// How it works
// - Strobe and auxiliary edges are timed on a reference clock at a quarter of the pixel rate.
// - A 240-pixel line yields 60 reference periods for the comparisons.
// - Timing registers keep six low bits; software writes 01H to 3BH.
// - First auxiliary output pulses every line between its own start and end.
// - Line inversion: bit 0 limits second auxiliary output to positive-common lines.
// - Frame inversion: bit 1 limits it to first display line, positive frames.
// - Line inversion: bit 2 limits third auxiliary output to negative-common lines.
// - Frame inversion: bit 3 limits it to first display line, negative frames.
// - Bit 7 makes auxiliary outputs the inverted red, green, blue strobes.
// - Gate output-enable one is active between its start and end counts.
// - Dummy select 0 inserts a dummy first line per frame; 1 does not.
// - A dummy line repeats the data of the previous input line.
// - Timing registers are written through the eight-bit serial configuration path.
`timescale 1ns/10ps
module panel_switch_signal_timing #(
    parameter int LINE_PIXELS = panel_timing_pkg::LINE_PIXELS,
    parameter int PIXELS_PER_REF = panel_timing_pkg::PIXELS_PER_REF
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic line_start_i,
    input wire logic frame_start_i,
    input wire logic pixel_tick_i,
    input wire logic common_polarity_i,
    input wire logic frame_inversion_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic red_switch_strobe_o,
    output logic green_switch_strobe_o,
    output logic blue_switch_strobe_o,
    output logic aux_output_one_o,
    output logic aux_output_two_o,
    output logic aux_output_three_o,
    output logic gate_output_enable_one_o,
    output logic repeat_prev_line_o
);

    // Reference periods per line, and the last count and divider values; the count saturates at REF_LAST.
    localparam int REF_PER_LINE = LINE_PIXELS / PIXELS_PER_REF;
    localparam logic [5:0] REF_LAST = 6'(REF_PER_LINE - 1);
    localparam logic [1:0] DIV_LAST = 2'(PIXELS_PER_REF - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode.

    // Maps a register index to its timing slot; valid is low for any other index.
    function automatic logic [4:0] timing_slot(input logic [7:0] addr);
        logic [4:0] slot;
        slot = 5'h00;
        if (addr >= panel_timing_pkg::RED_START_IDX && addr <= panel_timing_pkg::AUX3_END_IDX) begin
            slot = {1'b1, 4'(addr - panel_timing_pkg::RED_START_IDX)};
        end else if (addr == panel_timing_pkg::GATE_ENABLE1_START_IDX) begin
            slot = {1'b1, panel_timing_pkg::GATE_START_SLOT};
        end else if (addr == panel_timing_pkg::GATE_ENABLE1_END_IDX) begin
            slot = {1'b1, panel_timing_pkg::GATE_END_SLOT};
        end
        return slot;
    endfunction : timing_slot

    // Timing and function registers take host writes at once; their shadows copy them at each line boundary.
    logic [5:0] timing_reg [0:panel_timing_pkg::TIMING_SLOTS-1];
    logic [5:0] timing_shadow_reg [0:panel_timing_pkg::TIMING_SLOTS-1];
    logic [7:0] aux_function_reg;
    logic [7:0] aux_function_shadow_reg;
    logic dummy_sel_reg;
    logic [4:0] wr_slot;
    logic [4:0] rd_slot;

    assign wr_slot = timing_slot(reg_addr_i);
    assign rd_slot = timing_slot(reg_addr_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers written from the serial configuration path.

    // Timing slots keep only the six low bits of the written byte.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < panel_timing_pkg::TIMING_SLOTS; i++) begin
                timing_reg[i] <= panel_timing_pkg::TIMING_RESET;
            end
        end else if (ce_i && reg_wr_i && wr_slot[4]) begin
            timing_reg[wr_slot[3:0]] <= reg_wdata_i[5:0];
        end
    end

    // Function register; prohibited bits are not stored and read back as zero.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            aux_function_reg <= panel_timing_pkg::AUX_FUNCTION_RESET;
        end else if (ce_i && reg_wr_i && reg_addr_i == panel_timing_pkg::AUX_OUTPUT_FUNCTION_IDX) begin
            aux_function_reg <= reg_wdata_i & panel_timing_pkg::AUX_FUNCTION_MASK;
        end
    end

    // Dummy line select keeps bit 0 only.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            dummy_sel_reg <= panel_timing_pkg::DUMMY_SEL_RESET;
        end else if (ce_i && reg_wr_i && reg_addr_i == panel_timing_pkg::DUMMY_LINE_SELECT_IDX) begin
            dummy_sel_reg <= reg_wdata_i[panel_timing_pkg::DUMMY_SEL_BIT];
        end
    end

    // Read data is registered; unmapped indices read as zero.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            if (rd_slot[4]) begin
                reg_rdata_o <= {2'b00, timing_reg[rd_slot[3:0]]};
            end else if (reg_addr_i == panel_timing_pkg::AUX_OUTPUT_FUNCTION_IDX) begin
                reg_rdata_o <= aux_function_reg;
            end else if (reg_addr_i == panel_timing_pkg::DUMMY_LINE_SELECT_IDX) begin
                reg_rdata_o <= {7'h00, dummy_sel_reg};
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-line shadows: settings change only at a line boundary so no strobe is cut.

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < panel_timing_pkg::TIMING_SLOTS; i++) begin
                timing_shadow_reg[i] <= panel_timing_pkg::TIMING_RESET;
            end
            aux_function_shadow_reg <= panel_timing_pkg::AUX_FUNCTION_RESET;
        end else if (ce_i && line_start_i) begin
            for (int i = 0; i < panel_timing_pkg::TIMING_SLOTS; i++) begin
                timing_shadow_reg[i] <= timing_reg[i];
            end
            aux_function_shadow_reg <= aux_function_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Quarter-pixel-rate reference counter.

    // The divider and the count restart together, so every line starts from reference count zero.
    logic [1:0] pix_div_reg;
    logic [5:0] ref_count_reg;

    // Four pixel ticks make one reference period; the count holds at the last period.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            pix_div_reg <= 2'h0;
            ref_count_reg <= 6'h00;
        end else if (ce_i) begin
            if (line_start_i) begin
                pix_div_reg <= 2'h0;
                ref_count_reg <= 6'h00;
            end else if (pixel_tick_i) begin
                if (pix_div_reg == DIV_LAST) begin
                    pix_div_reg <= 2'h0;
                    if (ref_count_reg != REF_LAST) begin
                        ref_count_reg <= ref_count_reg + 6'h01;
                    end
                end else begin
                    pix_div_reg <= pix_div_reg + 2'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Line position within the frame, dummy line and common polarity per line.

    // With dummy select 0 the first line of a frame is the dummy line and the second is the first display line.
    // The index only has to tell lines 0, 1 and later apart, so two saturating bits are enough.
    logic [1:0] line_index_reg;
    logic line_pol_reg;
    logic dummy_line_reg;
    logic first_display_reg;
    logic [1:0] line_index_next;
    logic dummy_line_next;

    // The line index counts lines of the frame and saturates at 3, from the fourth line on.
    assign line_index_next = frame_start_i ? 2'h0 : ((line_index_reg == 2'h3) ? 2'h3 : line_index_reg + 2'h1);
    assign dummy_line_next = (line_index_next == 2'h0) && !dummy_sel_reg;

    // Line state is captured at the line boundary and holds through the line.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            line_index_reg <= 2'h3;
            line_pol_reg <= 1'b0;
            dummy_line_reg <= 1'b0;
            first_display_reg <= 1'b0;
        end else if (ce_i && line_start_i) begin
            line_index_reg <= line_index_next;
            line_pol_reg <= common_polarity_i;
            dummy_line_reg <= dummy_line_next;
            first_display_reg <= dummy_sel_reg ? (line_index_next == 2'h0) : (line_index_next == 2'h1);
        end
    end

    // The data path repeats the previous input line while this flag is high.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            repeat_prev_line_o <= 1'b0;
        end else if (ce_i) begin
            repeat_prev_line_o <= dummy_line_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe windows for the three switches, three auxiliary outputs and gate enable.

    // Slots pair up as start and end: red, green, blue, three auxiliaries, then the gate enable.
    // Window g reads slots 2g and 2g+1, which is why the gate pair sits in slots 12 and 13.
    logic [6:0] window_active;

    for (genvar g = 0; g < 7; g++) begin : gen_window
        strobe_window #(
            .WIDTH(panel_timing_pkg::TIMING_WIDTH)
        ) u_window (
            .sys_clk_i(sys_clk_i),
            .nrst_i(nrst_i),
            .ce_i(ce_i),
            .line_start_i(line_start_i),
            .ref_count_i(ref_count_reg),
            .start_i(timing_shadow_reg[2 * g]),
            .end_i(timing_shadow_reg[2 * g + 1]),
            .active_o(window_active[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Line qualification of the second and third auxiliary outputs.

    logic aux_two_line_en;
    logic aux_three_line_en;

    // Line inversion filters by line polarity; frame inversion by first display line.
    // The inversion mode is read live, since the register that holds it lies outside this block.
    always_comb begin
        aux_two_line_en = 1'b1;
        aux_three_line_en = 1'b1;
        if (!frame_inversion_i) begin
            if (aux_function_shadow_reg[panel_timing_pkg::AUX2_LINE_POS_BIT]) begin
                aux_two_line_en = line_pol_reg;
            end
            if (aux_function_shadow_reg[panel_timing_pkg::AUX3_LINE_NEG_BIT]) begin
                aux_three_line_en = !line_pol_reg;
            end
        end else begin
            if (aux_function_shadow_reg[panel_timing_pkg::AUX2_FRAME_POS_BIT]) begin
                aux_two_line_en = first_display_reg && line_pol_reg;
            end
            if (aux_function_shadow_reg[panel_timing_pkg::AUX3_FRAME_NEG_BIT]) begin
                aux_three_line_en = first_display_reg && !line_pol_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output flops.

    // Colour switches and the gate enable follow their windows directly.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            red_switch_strobe_o <= 1'b0;
            green_switch_strobe_o <= 1'b0;
            blue_switch_strobe_o <= 1'b0;
            gate_output_enable_one_o <= 1'b0;
        end else if (ce_i) begin
            red_switch_strobe_o <= window_active[0];
            green_switch_strobe_o <= window_active[1];
            blue_switch_strobe_o <= window_active[2];
            gate_output_enable_one_o <= window_active[6];
        end
    end

    // Auxiliary outputs either invert the colour windows or follow their own windows.
    // The function shadow is used, so a mode change never splits one line between two behaviours.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            aux_output_one_o <= 1'b0;
            aux_output_two_o <= 1'b0;
            aux_output_three_o <= 1'b0;
        end else if (ce_i) begin
            if (aux_function_shadow_reg[panel_timing_pkg::AUX_INVERT_BIT]) begin
                aux_output_one_o <= !window_active[0];
                aux_output_two_o <= !window_active[1];
                aux_output_three_o <= !window_active[2];
            end else begin
                aux_output_one_o <= window_active[3];
                aux_output_two_o <= window_active[4] && aux_two_line_en;
                aux_output_three_o <= window_active[5] && aux_three_line_en;
            end
        end
    end

endmodule : panel_switch_signal_timing

// file: test/panel_switch_signal_timing_sva.sv
// Checker for the panel switch strobe timing block, bound to its top module.
// Assumes one clock, a synchronous active-low reset and the register map of the package.
`timescale 1ns/10ps
module panel_switch_signal_timing_sva #(
    parameter int LINE_PIXELS = 240,
    parameter int PIXELS_PER_REF = 4
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic line_start_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic red_switch_strobe_o,
    input wire logic green_switch_strobe_o,
    input wire logic blue_switch_strobe_o,
    input wire logic aux_output_one_o,
    input wire logic aux_output_two_o,
    input wire logic aux_output_three_o,
    input wire logic gate_output_enable_one_o,
    input wire logic repeat_prev_line_o
);
    // All strobe outputs in one vector.
    wire logic [6:0] outs = {gate_output_enable_one_o, aux_output_three_o, aux_output_two_o, aux_output_one_o,
                             blue_switch_strobe_o, green_switch_strobe_o, red_switch_strobe_o};
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////////////
    chk_reset_quiet: assert property (
        disable iff (1'b0) !nrst_i |=> outs == 7'h00 && !repeat_prev_line_o)
        else $error("outputs not quiet after reset");
    chk_line_drop: assert property (
        line_start_i && ce_i ##1 ce_i |=> !red_switch_strobe_o && !green_switch_strobe_o
            && !blue_switch_strobe_o && !gate_output_enable_one_o)
        else $error("strobe survived a line boundary");
    chk_rdata_unmapped: assert property (
        ce_i && !(reg_addr_i inside {[8'h24:8'h33]}) |=> reg_rdata_o == 8'h00)
        else $error("unmapped index read nonzero");
    chk_slot_bits: assert property (
        ce_i && reg_addr_i inside {[8'h24:8'h2F], 8'h31, 8'h32} |=> reg_rdata_o[7:6] == 2'h0)
        else $error("timing slot upper bits set");
    chk_func_bits: assert property (
        ce_i && reg_addr_i == 8'h30 |=> reg_rdata_o[6:4] == 3'h0)
        else $error("function reserved bits set");
    chk_dummy_bits: assert property (
        ce_i && reg_addr_i == 8'h33 |=> reg_rdata_o[7:1] == 7'h00)
        else $error("dummy select upper bits set");
    chk_write_readback: assert property (
        ce_i && reg_wr_i && reg_addr_i inside {[8'h24:8'h2F]} ##1 ce_i && !reg_wr_i && $stable(reg_addr_i)
            |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h3F))
        else $error("timing slot readback wrong");
    chk_ce_freeze: assert property (
        !ce_i |=> $stable(outs) && $stable(reg_rdata_o) && $stable(repeat_prev_line_o))
        else $error("outputs moved with clock enable low");
    chk_repeat_edge: assert property (
        $changed(repeat_prev_line_o) && $past(ce_i) && $past(ce_i, 2) |-> $past(line_start_i, 2))
        else $error("dummy flag changed away from a line boundary");
endmodule : panel_switch_signal_timing_sva

bind panel_switch_signal_timing panel_switch_signal_timing_sva #(
    .LINE_PIXELS(LINE_PIXELS), .PIXELS_PER_REF(PIXELS_PER_REF)
) u_sva (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .line_start_i(line_start_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .red_switch_strobe_o(red_switch_strobe_o), .green_switch_strobe_o(green_switch_strobe_o),
    .blue_switch_strobe_o(blue_switch_strobe_o), .aux_output_one_o(aux_output_one_o),
    .aux_output_two_o(aux_output_two_o), .aux_output_three_o(aux_output_three_o),
    .gate_output_enable_one_o(gate_output_enable_one_o), .repeat_prev_line_o(repeat_prev_line_o)
);

// file: test/panel_gate_model.sv
// Panel switch and gate driver stand-in: counts pulses on each control line.
// Assumes the bench clears it at every line boundary; it only listens.
`timescale 1ns/10ps
module panel_gate_model (
    input wire logic sys_clk_i,
    input wire logic clr_i,
    input wire logic [6:0] drive_i,
    output logic [6:0][3:0] rises_o
);
    logic [6:0] last_reg;
    // Counts rising edges since the last clear, one counter per line.
    always_ff @(posedge sys_clk_i) begin
        last_reg <= drive_i;
        for (int i = 0; i < 7; i++) begin
            if (clr_i) begin
                rises_o[i] <= 4'h0;
            end else if (drive_i[i] && !last_reg[i]) begin
                rises_o[i] <= rises_o[i] + 4'h1;
            end
        end
    end
endmodule : panel_gate_model

// file: test/tb_top.sv
// Self-checking bench for the panel switch strobe timing block.
// Assumes a 50 ns clock; inputs change on the falling edge.
`timescale 1ns/10ps
module tb_top;
    logic sys_clk_i, nrst_i, ce_i, line_start_i, frame_start_i, pixel_tick_i;
    logic common_polarity_i, frame_inversion_i, reg_wr_i, clr;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic red_o, green_o, blue_o, aux1_o, aux2_o, aux3_o, gate_o, repeat_o;
    logic [6:0][3:0] rises;
    int err_count = 0;
    int tests_run = 0;
    int rise_at [7];
    int fall_at [7];
    int inv_bad, rep_seen;
    logic [7:0] st [7] = '{8'h05, 8'h0C, 8'h1E, 8'h02, 8'h10, 8'h30, 8'h01};
    logic [7:0] en [7] = '{8'h0A, 8'h14, 8'h28, 8'h3B, 8'h20, 8'h38, 8'h3A};
    wire logic [6:0] outs = {gate_o, aux3_o, aux2_o, aux1_o, blue_o, green_o, red_o};
    ////////////////////////////////////////////////////////////////////////////////
    panel_switch_signal_timing u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .line_start_i(line_start_i), .frame_start_i(frame_start_i), .pixel_tick_i(pixel_tick_i),
        .common_polarity_i(common_polarity_i), .frame_inversion_i(frame_inversion_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .red_switch_strobe_o(red_o), .green_switch_strobe_o(green_o), .blue_switch_strobe_o(blue_o),
        .aux_output_one_o(aux1_o), .aux_output_two_o(aux2_o), .aux_output_three_o(aux3_o),
        .gate_output_enable_one_o(gate_o), .repeat_prev_line_o(repeat_o));
    panel_gate_model u_panel (.sys_clk_i(sys_clk_i), .clr_i(clr), .drive_i(outs), .rises_o(rises));
    // Free-running system clock.
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("Checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    // One register write, strobe held for one clock.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
    endtask : wr
    // Presents an index and checks the read data one clock later.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        @(negedge sys_clk_i);
        chk(nm, e, reg_rdata_o);
    endtask : rd_chk
    function automatic logic [7:0] slot_addr(input int i);
        return (i < 6) ? 8'(8'h24 + 2 * i) : 8'h31;
    endfunction : slot_addr
    // Runs one line with pixel ticks every clock, recording edges; optional write mid-line.
    task automatic run_line(input logic f, input logic p, input logic [7:0] ma, input logic [7:0] md);
        @(negedge sys_clk_i);
        line_start_i = 1'b1;
        frame_start_i = f;
        common_polarity_i = p;
        clr = 1'b1;
        @(negedge sys_clk_i);
        line_start_i = 1'b0;
        frame_start_i = 1'b0;
        clr = 1'b0;
        inv_bad = 0;
        rep_seen = 0;
        for (int i = 0; i < 7; i++) begin
            rise_at[i] = -1;
            fall_at[i] = -1;
        end
        for (int n = 1; n < 250; n++) begin
            @(negedge sys_clk_i);
            reg_wr_i = (ma != 8'h00 && n == 20);
            reg_addr_i = ma;
            reg_wdata_i = md;
            for (int i = 0; i < 7; i++) begin
                if (outs[i] === 1'b1 && rise_at[i] < 0) rise_at[i] = n;
                if (outs[i] === 1'b0 && rise_at[i] >= 0 && fall_at[i] < 0) fall_at[i] = n;
            end
            if (outs[5:3] !== ~outs[2:0]) inv_bad++;
            if (repeat_o === 1'b1) rep_seen = 1;
        end
    endtask : run_line
    // Runs a line and checks the second and third auxiliary pulses and the dummy flag.
    task automatic mode_line(input logic f, input logic p, input int e2, input int e3, input int er);
        run_line(f, p, 8'h00, 8'h00);
        chk("aux_two_pulses", e2, rises[4]);
        chk("aux_three_pulses", e3, rises[5]);
        chk("dummy_flag", er, rep_seen);
    endtask : mode_line
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, register map, timing, auxiliary modes, dummy line.
    initial begin
        {nrst_i, line_start_i, frame_start_i, common_polarity_i, frame_inversion_i, reg_wr_i, clr} = 7'h00;
        ce_i = 1'b1;
        pixel_tick_i = 1'b1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        repeat (5) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        rd_chk(8'h24, 8'h00, "red_start_reset");
        rd_chk(8'h30, 8'h00, "function_reset");
        rd_chk(8'h33, 8'h01, "dummy_reset");
        wr(8'h24, 8'hFF);
        rd_chk(8'h24, 8'h3F, "slot_low_bits");
        wr(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h8F, "function_mask");
        wr(8'h40, 8'h5A);
        rd_chk(8'h40, 8'h00, "unmapped_read");
        ce_i = 1'b0;
        wr(8'h24, 8'h11);
        ce_i = 1'b1;
        rd_chk(8'h24, 8'h3F, "frozen_write");
        for (int i = 0; i < 7; i++) begin
            wr(slot_addr(i), st[i]);
            wr(slot_addr(i) + 8'h01, en[i]);
        end
        wr(8'h30, 8'h00);
        run_line(1'b0, 1'b1, 8'h24, 8'h08);
        for (int i = 0; i < 7; i++) begin
            chk("strobe_width", 4 * (en[i] - st[i]), fall_at[i] - rise_at[i]);
            chk("strobe_start", 1, rise_at[i] >= 4 * st[i] && rise_at[i] <= 4 * st[i] + 6);
            chk("strobe_pulses", 1, rises[i]);
        end
        run_line(1'b0, 1'b1, 8'h00, 8'h00);
        chk("red_reload_width", 4 * (8'h0A - 8'h08), fall_at[0] - rise_at[0]);
        wr(8'h30, 8'h05);
        mode_line(1'b0, 1'b1, 1, 0, 0);
        mode_line(1'b0, 1'b0, 0, 1, 0);
        frame_inversion_i = 1'b1;
        wr(8'h30, 8'h0A);
        mode_line(1'b1, 1'b1, 1, 0, 0);
        mode_line(1'b0, 1'b1, 0, 0, 0);
        mode_line(1'b1, 1'b0, 0, 1, 0);
        wr(8'h33, 8'h00);
        mode_line(1'b1, 1'b0, 0, 0, 1);
        mode_line(1'b0, 1'b0, 0, 1, 0);
        wr(8'h33, 8'h01);
        frame_inversion_i = 1'b0;
        wr(8'h30, 8'h80);
        run_line(1'b0, 1'b1, 8'h00, 8'h00);
        chk("aux_inverse", 0, inv_bad);
        close_out();
    end
endmodule : tb_top
